// *** hdl/dtcp_pkg.sv ***
// Purpose: Shared constants and carrier types for the dual timer with capture and PWM.
// Assumes: One clock, synchronous active-high reset, 32-bit big-endian bus words.
// Notes: Bit positions are internal (bit 31 is the MSB); bus label k sits at bit 31-k.
package dtcp_pkg;
  localparam int unsigned CNT_W = 32;

  localparam logic [4:0] OFF_TIMER0_CONTROL_STATUS = 5'h00;
  localparam logic [4:0] OFF_TIMER0_LOAD_CAPTURE   = 5'h04;
  localparam logic [4:0] OFF_TIMER0_COUNT_VALUE    = 5'h08;
  localparam logic [4:0] OFF_TIMER1_CONTROL_STATUS = 5'h10;
  localparam logic [4:0] OFF_TIMER1_LOAD_CAPTURE   = 5'h14;
  localparam logic [4:0] OFF_TIMER1_COUNT_VALUE    = 5'h18;

  localparam int unsigned BIT_MODE    = 0;
  localparam int unsigned BIT_DIR     = 1;
  localparam int unsigned BIT_GEN_EN  = 2;
  localparam int unsigned BIT_RELOAD  = 4;
  localparam int unsigned BIT_LOAD    = 5;
  localparam int unsigned BIT_IRQ_EN  = 6;
  localparam int unsigned BIT_ENABLE  = 7;
  localparam int unsigned BIT_INTERRUPT_STATUS_FLAG    = 8;
  localparam int unsigned BIT_PWM     = 9;
  localparam int unsigned BIT_ENALL   = 10;

  localparam logic [31:0] CSR_WR_MASK = 32'h0000_02f7;
  localparam logic [31:0] CSR_RESET   = 32'h0000_0000;
  localparam logic [31:0] LD_RESET    = 32'h0000_0000;
  localparam logic [31:0] CNT_RESET   = 32'h0000_0000;

  localparam int unsigned PWM_EXTRA_CYCLES = 2;

  typedef struct packed {
    logic capture_mode;
    logic count_down;
    logic reload;
    logic load;
    logic gen_en;
    logic enable;
  } dtcp_ctrl_s;

  typedef struct packed {
    logic             evt;
    logic             cap_evt;
    logic             gen_pulse;
    logic [CNT_W-1:0] cap_value;
    logic [CNT_W-1:0] count;
  } dtcp_stat_s;
endpackage

// *** hdl/dtcp_channel.sv ***
// Purpose: One timer channel: counter, reload or hold, capture synchroniser and events.
// Assumes: Control comes from the owning register file on the same clock.
// Notes: The capture pin is asynchronous and passes two flip-flops before use.
`timescale 1ns/1ns
module dtcp_channel #(
  parameter bit CAPT_ACTIVE_HIGH = 1'b1
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire dtcp_pkg::dtcp_ctrl_s       ctrl,
  input  wire logic [dtcp_pkg::CNT_W-1:0] load_value,
  input  wire logic                       restart,
  input  wire logic                       capture_pin,
  output dtcp_pkg::dtcp_stat_s            stat
);
  localparam int unsigned W = dtcp_pkg::CNT_W;

  logic         cap_meta_reg;
  logic         cap_sync_reg;
  logic         cap_prev_reg;
  logic [W-1:0] count_reg;
  logic         reload_pend_reg;
  logic         held_reg;
  logic         evt_reg;
  logic         cap_evt_reg;
  logic         gen_pulse_reg;
  logic [W-1:0] cap_value_reg;
  logic         active_now;
  logic         active_prev;
  logic         run;
  logic         wrap;
  logic         cap_now;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cap_meta_reg <= 1'b0;
      cap_sync_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else begin
      cap_meta_reg <= capture_pin;
      cap_sync_reg <= cap_meta_reg;
      cap_prev_reg <= cap_sync_reg;
    end
  end

  assign active_now  = CAPT_ACTIVE_HIGH ? cap_sync_reg : ~cap_sync_reg;
  assign active_prev = CAPT_ACTIVE_HIGH ? cap_prev_reg : ~cap_prev_reg;
  assign cap_now     = ctrl.enable && ctrl.capture_mode && active_now && !active_prev;
  assign run         = ctrl.enable && !ctrl.load && !held_reg && !reload_pend_reg;
  assign wrap        = run && (ctrl.count_down ? (count_reg == '0) : (count_reg == '1));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_reg <= dtcp_pkg::CNT_RESET[W-1:0];
    end else if (restart || ctrl.load || reload_pend_reg) begin
      count_reg <= load_value;
    end else if (run) begin
      count_reg <= ctrl.count_down ? count_reg - 1'b1 : count_reg + 1'b1;
    end
  end

  // The wrapped value stands one cycle before the reload, which gives the extra clock.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reload_pend_reg <= 1'b0;
      held_reg        <= 1'b0;
    end else if (restart || ctrl.load) begin
      reload_pend_reg <= 1'b0;
      held_reg        <= 1'b0;
    end else begin
      reload_pend_reg <= wrap && !ctrl.capture_mode && ctrl.reload;
      if (wrap && !ctrl.capture_mode && !ctrl.reload) begin
        held_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evt_reg       <= 1'b0;
      cap_evt_reg   <= 1'b0;
      gen_pulse_reg <= 1'b0;
      cap_value_reg <= dtcp_pkg::CNT_RESET[W-1:0];
    end else begin
      evt_reg       <= (wrap && !ctrl.capture_mode) || cap_now;
      cap_evt_reg   <= cap_now;
      gen_pulse_reg <= wrap && !ctrl.capture_mode && ctrl.gen_en;
      if (cap_now) begin
        cap_value_reg <= count_reg;
      end
    end
  end

  assign stat = '{evt: evt_reg, cap_evt: cap_evt_reg, gen_pulse: gen_pulse_reg,
                  cap_value: cap_value_reg, count: count_reg};
endmodule

// *** hdl/dtcp_dual_timer.sv ***
// Purpose: Two-channel timer with capture, paired PWM and one interrupt, as a bus slave.
// Assumes: Single clock clk_sys at 125 MHz; bus master holds select until the acknowledge.
// Notes: Bus vectors keep big-endian labels, so label 0 is the most significant bit.
`timescale 1ns/1ns
module dtcp_dual_timer #(
  parameter logic [31:0] BASE_ADDR             = 32'h0000_0000,
  parameter bit          CAPT0_ACTIVE_HIGH     = 1'b1,
  parameter bit          CAPT1_ACTIVE_HIGH     = 1'b1,
  parameter bit          GEN_OUT0_ACTIVE_LEVEL = 1'b1,
  parameter bit          GEN_OUT1_ACTIVE_LEVEL = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [0:31] OPB_ABus,
  input  wire logic [0:3]  OPB_BE,
  input  wire logic [0:31] OPB_DBus,
  input  wire logic        OPB_RNW,
  input  wire logic        OPB_select,
  output logic      [0:31] Sl_DBus,
  output logic             Sl_xferAck,
  output logic             Sl_errAck,
  output logic             Sl_retry,
  output logic             Sl_toutSup,
  input  wire logic        capture_in0,
  input  wire logic        capture_in1,
  output logic             generate_pulse_out0,
  output logic             generate_pulse_out1,
  output logic             pwm_output,
  output logic             interrupt_out
);
  localparam int unsigned W = dtcp_pkg::CNT_W;

  logic [31:0]          abus_w;
  logic [31:0]          wdata_w;
  logic [3:0]           be_w;
  logic [31:0]          wmask;
  logic [4:0]           off;
  logic                 hit;
  logic                 wr;
  logic                 rd;
  logic [1:0]           wr_csr;
  logic [1:0]           wr_ld;
  logic [1:0]           rd_ld;
  logic [1:0]           interrupt_status_flag_clr;
  logic [1:0]           cap_take;
  logic                 enall_set;
  logic                 enall_clr;
  logic                 pwm_on;
  logic                 restart1;
  logic [31:0]          csr_reg [2];
  logic [31:0]          ld_reg [2];
  logic [1:0]           interrupt_status_flag_reg;
  logic [1:0]           cap_full_reg;
  logic                 enall_reg;
  logic [31:0]          csr_rd [2];
  logic [31:0]          cnt_rd [2];
  logic [31:0]          rdata;
  logic [1:0]           capture_pins;
  logic [1:0]           restarts;
  dtcp_pkg::dtcp_ctrl_s ctrl [2];
  dtcp_pkg::dtcp_stat_s stat [2];

  // Bus lanes are reordered so that internal bit 31 and be_w[3] are the most significant.
  assign abus_w  = OPB_ABus;
  assign wdata_w = OPB_DBus;
  assign be_w    = OPB_BE;
  assign wmask   = {{8{be_w[3]}}, {8{be_w[2]}}, {8{be_w[1]}}, {8{be_w[0]}}};
  assign off     = {abus_w[4:2], 2'b00};
  assign hit     = OPB_select && !Sl_xferAck && (abus_w[31:5] == BASE_ADDR[31:5]);
  assign wr      = hit && !OPB_RNW;
  assign rd      = hit && OPB_RNW;

  assign wr_csr[0] = wr && (off == dtcp_pkg::OFF_TIMER0_CONTROL_STATUS);
  assign wr_csr[1] = wr && (off == dtcp_pkg::OFF_TIMER1_CONTROL_STATUS);
  assign wr_ld[0]  = wr && (off == dtcp_pkg::OFF_TIMER0_LOAD_CAPTURE);
  assign wr_ld[1]  = wr && (off == dtcp_pkg::OFF_TIMER1_LOAD_CAPTURE);
  assign rd_ld[0]  = rd && (off == dtcp_pkg::OFF_TIMER0_LOAD_CAPTURE);
  assign rd_ld[1]  = rd && (off == dtcp_pkg::OFF_TIMER1_LOAD_CAPTURE);

  assign enall_set = (|wr_csr) && be_w[dtcp_pkg::BIT_ENALL/8] && wdata_w[dtcp_pkg::BIT_ENALL];
  assign enall_clr = (|wr_csr) && be_w[dtcp_pkg::BIT_ENALL/8] && !wdata_w[dtcp_pkg::BIT_ENALL];

  assign capture_pins = {capture_in1, capture_in0};
  assign restarts     = {restart1, 1'b0};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      assign interrupt_status_flag_clr[g] = wr_csr[g] && be_w[dtcp_pkg::BIT_INTERRUPT_STATUS_FLAG/8]
                           && wdata_w[dtcp_pkg::BIT_INTERRUPT_STATUS_FLAG];
      assign ctrl[g] = '{capture_mode: csr_reg[g][dtcp_pkg::BIT_MODE],
                         count_down:   csr_reg[g][dtcp_pkg::BIT_DIR],
                         reload:       csr_reg[g][dtcp_pkg::BIT_RELOAD],
                         load:         csr_reg[g][dtcp_pkg::BIT_LOAD],
                         gen_en:       csr_reg[g][dtcp_pkg::BIT_GEN_EN],
                         enable:       csr_reg[g][dtcp_pkg::BIT_ENABLE]};
      // A capture in the cycle of a load-register read is kept: the set wins.
      assign cap_take[g] = stat[g].cap_evt
                           && (ctrl[g].reload || !cap_full_reg[g] || rd_ld[g]);
      assign csr_rd[g] = (csr_reg[g] & dtcp_pkg::CSR_WR_MASK)
                         | ({31'h0000_0000, interrupt_status_flag_reg[g]} << dtcp_pkg::BIT_INTERRUPT_STATUS_FLAG)
                         | ({31'h0000_0000, enall_reg} << dtcp_pkg::BIT_ENALL);
      assign cnt_rd[g] = 32'(stat[g].count);

      dtcp_channel #(
        .CAPT_ACTIVE_HIGH ((g == 0) ? CAPT0_ACTIVE_HIGH : CAPT1_ACTIVE_HIGH)
      ) u_channel (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .ctrl        (ctrl[g]),
        .load_value  (ld_reg[g][W-1:0]),
        .restart     (restarts[g]),
        .capture_pin (capture_pins[g]),
        .stat        (stat[g])
      );
    end
  endgenerate

  // Control and status: writable fields by byte lane, the global enable sets both channels.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      csr_reg[0] <= dtcp_pkg::CSR_RESET;
      csr_reg[1] <= dtcp_pkg::CSR_RESET;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (wr_csr[ch]) begin
          csr_reg[ch] <= (csr_reg[ch] & ~(wmask & dtcp_pkg::CSR_WR_MASK))
                         | (wdata_w & wmask & dtcp_pkg::CSR_WR_MASK);
        end
        if (enall_set) begin
          csr_reg[ch][dtcp_pkg::BIT_ENABLE] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enall_reg <= 1'b0;
    end else if (enall_set) begin
      enall_reg <= 1'b1;
    end else if (enall_clr) begin
      enall_reg <= 1'b0;
    end
  end

  // The flag records every event whatever the interrupt enable; set wins over clear.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interrupt_status_flag_reg <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        interrupt_status_flag_reg[ch] <= (interrupt_status_flag_reg[ch] && !interrupt_status_flag_clr[ch]) || stat[ch].evt;
      end
    end
  end

  // Load registers take software writes and captured counts; a capture wins over a write.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ld_reg[0] <= dtcp_pkg::LD_RESET;
      ld_reg[1] <= dtcp_pkg::LD_RESET;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (cap_take[ch]) begin
          ld_reg[ch] <= 32'(stat[ch].cap_value);
        end else if (wr_ld[ch]) begin
          ld_reg[ch] <= (ld_reg[ch] & ~wmask) | (wdata_w & wmask);
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cap_full_reg <= 2'h0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (cap_take[ch]) begin
          cap_full_reg[ch] <= 1'b1;
        end else if (rd_ld[ch]) begin
          cap_full_reg[ch] <= 1'b0;
        end
      end
    end
  end

  // Count registers appear only in the read path, so writes to them fall away.
  always_comb begin
    rdata = 32'h0000_0000;
    case (off)
      dtcp_pkg::OFF_TIMER0_CONTROL_STATUS: rdata = csr_rd[0];
      dtcp_pkg::OFF_TIMER0_LOAD_CAPTURE:   rdata = ld_reg[0];
      dtcp_pkg::OFF_TIMER0_COUNT_VALUE:    rdata = cnt_rd[0];
      dtcp_pkg::OFF_TIMER1_CONTROL_STATUS: rdata = csr_rd[1];
      dtcp_pkg::OFF_TIMER1_LOAD_CAPTURE:   rdata = ld_reg[1];
      dtcp_pkg::OFF_TIMER1_COUNT_VALUE:    rdata = cnt_rd[1];
      default:                             rdata = 32'h0000_0000;
    endcase
  end

  // Acknowledge one cycle after select; the data bus is zero whenever not acknowledging.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      Sl_xferAck <= 1'b0;
      Sl_DBus    <= 32'h0000_0000;
      Sl_errAck  <= 1'b0;
      Sl_retry   <= 1'b0;
      Sl_toutSup <= 1'b0;
    end else begin
      Sl_xferAck <= hit;
      Sl_DBus    <= rd ? rdata : 32'h0000_0000;
      Sl_errAck  <= 1'b0;
      Sl_retry   <= 1'b0;
      Sl_toutSup <= 1'b0;
    end
  end

  // Channel 0 pulse starts the high phase and restarts channel 1, whose pulse ends it.
  assign pwm_on = csr_reg[0][dtcp_pkg::BIT_PWM] && csr_reg[1][dtcp_pkg::BIT_PWM]
                  && !csr_reg[0][dtcp_pkg::BIT_MODE] && !csr_reg[1][dtcp_pkg::BIT_MODE];
  assign restart1 = pwm_on && stat[0].gen_pulse;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwm_output <= 1'b0;
    end else if (!pwm_on) begin
      pwm_output <= 1'b0;
    end else if (stat[0].gen_pulse) begin
      pwm_output <= 1'b1;
    end else if (stat[1].gen_pulse) begin
      pwm_output <= 1'b0;
    end
  end

  // Generate outputs take the build-time level; PWM uses the raw pulses regardless.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      generate_pulse_out0 <= !GEN_OUT0_ACTIVE_LEVEL;
      generate_pulse_out1 <= !GEN_OUT1_ACTIVE_LEVEL;
    end else begin
      generate_pulse_out0 <= GEN_OUT0_ACTIVE_LEVEL ? stat[0].gen_pulse : !stat[0].gen_pulse;
      generate_pulse_out1 <= GEN_OUT1_ACTIVE_LEVEL ? stat[1].gen_pulse : !stat[1].gen_pulse;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interrupt_out <= 1'b0;
    end else begin
      interrupt_out <= (interrupt_status_flag_reg[0] && csr_reg[0][dtcp_pkg::BIT_IRQ_EN])
                       || (interrupt_status_flag_reg[1] && csr_reg[1][dtcp_pkg::BIT_IRQ_EN]);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Helper state that measures PWM high phases with no bus write in between.
  logic [32:0] pwm_high_len;
  logic        pwm_quiet;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwm_high_len <= 33'h0_0000_0000;
      pwm_quiet    <= 1'b0;
    end else begin
      pwm_high_len <= pwm_output ? pwm_high_len + 33'h0_0000_0001 : 33'h0_0000_0000;
      pwm_quiet    <= pwm_output ? (pwm_quiet && !wr) : !wr;
    end
  end

  sequence s_cap0_taken;
    stat[0].cap_evt && (ctrl[0].reload || !cap_full_reg[0]);
  endsequence

  sequence s_cap0_refused;
    stat[0].cap_evt && !ctrl[0].reload && cap_full_reg[0] && !rd_ld[0] && !wr_ld[0];
  endsequence

  sequence s_pwm_fall_clean;
    $fell(pwm_output) && pwm_on && pwm_quiet && ctrl[1].count_down && !ctrl[1].load
    && (ld_reg[1] < ld_reg[0]);
  endsequence

  property p_cap_copy;
    s_cap0_taken |=> ld_reg[0] == $past(stat[0].count, 2);
  endproperty

  property p_hold_keeps;
    s_cap0_refused |=> $stable(ld_reg[0]);
  endproperty

  property p_pwm_high;
    s_pwm_fall_clean |-> pwm_high_len == ({1'b0, ld_reg[1]} + 33'(dtcp_pkg::PWM_EXTRA_CYCLES));
  endproperty

  a_cap_copy_count: assert property (p_cap_copy)
    else $error("Capture did not store the counter value.");
  a_hold_keeps_first: assert property (p_hold_keeps)
    else $error("Held capture value was overwritten.");
  a_pwm_high_time: assert property (p_pwm_high)
    else $error("PWM high time differs from load value plus two.");
  a_interrupt_status_flag_event_sets: assert property (stat[0].evt |=> interrupt_status_flag_reg[0])
    else $error("Event did not set the interrupt flag.");
  a_interrupt_status_flag_write_zero: assert property (interrupt_status_flag_reg[0] && !interrupt_status_flag_clr[0] |=> interrupt_status_flag_reg[0])
    else $error("Interrupt flag lost without a written one.");
  a_interrupt_status_flag_clear_holds: assert property (interrupt_status_flag_clr[0] && !stat[0].evt ##1 !stat[0].evt
                                       |-> !interrupt_status_flag_reg[0])
    else $error("Cleared flag came back without an event.");
  a_no_event_off: assert property (!ctrl[0].enable |=> !stat[0].evt)
    else $error("Event raised while the channel was disabled.");
  a_irq_raised: assert property (interrupt_status_flag_reg[1] && csr_reg[1][dtcp_pkg::BIT_IRQ_EN]
                                 |=> interrupt_out)
    else $error("Interrupt output missed an enabled flag.");
  a_irq_gated: assert property (!(interrupt_status_flag_reg[0] && csr_reg[0][dtcp_pkg::BIT_IRQ_EN])
                                && !(interrupt_status_flag_reg[1] && csr_reg[1][dtcp_pkg::BIT_IRQ_EN])
                                |=> !interrupt_out)
    else $error("Interrupt output high with no enabled flag.");
  a_reload_after_wrap: assert property (stat[0].gen_pulse && ctrl[0].reload && !ctrl[0].load
                                        |=> stat[0].count == $past(ld_reg[0][W-1:0]))
    else $error("Counter did not reload after rollover.");
  a_ack_single: assert property (Sl_xferAck |=> !Sl_xferAck)
    else $error("Acknowledge lasted more than one cycle.");
  a_dbus_idle_zero: assert property (!Sl_xferAck |-> Sl_DBus == 32'h0000_0000)
    else $error("Data bus not zero outside an acknowledge.");
endmodule

// *** test/dtcp_bus_master.sv ***
// Purpose: Bus master model that makes single register accesses to the dual timer.
// Assumes: Requests start at a falling edge and stay up until the acknowledge is seen or eight cycles pass.
// Notes: Released write data is inverted so stale values cannot pass for fresh ones.
`timescale 1ns/1ns
module dtcp_bus_master (
  input  wire logic        clk_sys,
  output logic      [0:31] OPB_ABus,
  output logic      [0:3]  OPB_BE,
  output logic      [0:31] OPB_DBus,
  output logic             OPB_RNW,
  output logic             OPB_select,
  input  wire logic [0:31] Sl_DBus,
  input  wire logic        Sl_xferAck
);
  initial begin
    OPB_ABus = 32'h0000_0000;
    OPB_BE = 4'h0;
    OPB_DBus = 32'h0000_0000;
    OPB_RNW = 1'b0;
    OPB_select = 1'b0;
  end

  // One access; the request stays unchanged until the acknowledge or at most eight cycles, then is released.
  task automatic access(input logic rnw, input logic [4:0] off, input logic [0:3] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    @(negedge clk_sys);
    OPB_ABus <= {27'h0, off};
    OPB_BE <= be;
    OPB_DBus <= wd;
    OPB_RNW <= rnw;
    OPB_select <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (Sl_xferAck !== 1'b1 && n < 8);
    rd = Sl_DBus;
    // A late or missing acknowledge is reported to the caller through ok.
    ok = (Sl_xferAck === 1'b1) && (n == 1);
    OPB_select <= 1'b0;
    OPB_DBus <= ~wd;
  endtask
endmodule

// *** test/test_dtcp_dual_timer.sv ***
// Purpose: Self-checking bench for the dual timer: registers, capture, interrupt and PWM.
// Assumes: Inputs change at the falling edge; every acknowledge pops one queued note.
// Notes: A note holds a mask and a value; a zero mask only consumes the acknowledge.
`timescale 1ns/1ns
module test_dtcp_dual_timer;
  logic        clk_sys;
  logic        reset;
  logic [0:31] abus;
  logic [0:3]  be;
  logic [0:31] wdata;
  logic        rnw;
  logic        sel;
  logic [0:31] sl_dbus;
  logic        ack;
  logic        cap0;
  logic        cap1;
  logic        pwm;
  logic        irq;
  logic        gen0;
  logic        gen1;
  logic        errack;
  logic        retry;
  logic        tsup;
  logic [63:0] notes[$];
  logic [63:0] note;
  int          fails;
  int          tests_run;
  int          cycles;

  dtcp_dual_timer #(.CAPT1_ACTIVE_HIGH(1'b0), .GEN_OUT0_ACTIVE_LEVEL(1'b1),
                    .GEN_OUT1_ACTIVE_LEVEL(1'b1)) dtcp_dual_timer_i (
    .clk_sys(clk_sys), .reset(reset), .OPB_ABus(abus), .OPB_BE(be), .OPB_DBus(wdata),
    .OPB_RNW(rnw), .OPB_select(sel), .Sl_DBus(sl_dbus), .Sl_xferAck(ack), .Sl_errAck(errack),
    .Sl_retry(retry), .Sl_toutSup(tsup), .capture_in0(cap0), .capture_in1(cap1),
    .generate_pulse_out0(gen0), .generate_pulse_out1(gen1), .pwm_output(pwm),
    .interrupt_out(irq));

  dtcp_bus_master dtcp_bus_master_i (
    .clk_sys(clk_sys), .OPB_ABus(abus), .OPB_BE(be), .OPB_DBus(wdata), .OPB_RNW(rnw),
    .OPB_select(sel), .Sl_DBus(sl_dbus), .Sl_xferAck(ack));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] off, input logic [31:0] d, input logic [0:3] b = 4'hf);
    logic [31:0] x;
    logic        ok;
    notes.push_back(64'h0);
    dtcp_bus_master_i.access(1'b0, off, b, d, x, ok);
    check(32'(ok), 32'h1);
  endtask

  task automatic rd(input logic [4:0] off, input logic [31:0] e, input logic [31:0] m,
                    output logic [31:0] v);
    logic ok;
    notes.push_back({m, e});
    dtcp_bus_master_i.access(1'b1, off, 4'hf, 32'h0000_0000, v, ok);
    check(32'(ok), 32'h1);
  endtask

  // Pulses the first capture pin and drives the second one to a random level.
  task automatic pulse;
    cap0 = 1'b1;
    cap1 = 1'($urandom);
    repeat (3) @(negedge clk_sys);
    cap0 = 1'b0;
    repeat (6) @(negedge clk_sys);
  endtask

  // Every acknowledge takes the oldest note and compares the read data under its mask.
  always @(negedge clk_sys) begin
    if (ack === 1'b1) begin
      note = notes.pop_front();
      check(sl_dbus & note[63:32], note[31:0] & note[63:32]);
      check(32'({errack, retry, tsup}), 32'h0);
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    logic [31:0] v;
    logic [31:0] a;
    logic [31:0] c;
    logic [31:0] l1;
    int          n;
    reset = 1'b1;
    cap0 = 1'b0;
    cap1 = 1'b0;
    void'($urandom(32'h6017));
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0, 32'hffff_ffff, v);
    wr(5'h08, $urandom);
    rd(5'h08, 32'h0, 32'hffff_ffff, v);
    a = $urandom;
    wr(5'h04, a);
    wr(5'h04, 32'h00aa_0000, 4'b0100);
    rd(5'h04, {a[31:24], 8'haa, a[15:0]}, 32'hffff_ffff, v);
    wr(5'h14, a);
    wr(5'h14, 32'h0000_5a5a, 4'b0011);
    rd(5'h14, {a[31:16], 16'h5a5a}, 32'hffff_ffff, v);
    wr(5'h00, 32'h0000_0001);
    pulse();
    rd(5'h00, 32'h0, 32'h100, v);
    rd(5'h10, 32'h0, 32'h100, v);
    wr(5'h00, 32'h0000_00c1);
    pulse();
    rd(5'h00, 32'h100, 32'h100, v);
    check(32'(irq), 32'h1);
    rd(5'h08, 32'h0, 32'h0, c);
    pulse();
    rd(5'h04, 32'h0, 32'h0, v);
    check(32'(v < c && v != 0), 32'h1);
    pulse();
    rd(5'h04, 32'h0, 32'h0, v);
    check(32'(v > c), 32'h1);
    wr(5'h00, 32'h0000_00d1);
    pulse();
    rd(5'h08, 32'h0, 32'h0, c);
    pulse();
    rd(5'h04, 32'h0, 32'h0, v);
    check(32'(v > c), 32'h1);
    rd(5'h00, 32'h100, 32'h100, v);
    wr(5'h00, 32'h0000_01d1);
    repeat (20) @(negedge clk_sys);
    rd(5'h00, 32'h0, 32'h100, v);
    check(32'(irq), 32'h0);
    wr(5'h00, 32'h0000_0091);
    pulse();
    rd(5'h00, 32'h100, 32'h100, v);
    check(32'(irq), 32'h0);
    wr(5'h00, 32'h0000_00d1);
    repeat (2) @(negedge clk_sys);
    check(32'(irq), 32'h1);
    wr(5'h00, 32'h0000_0083);
    rd(5'h08, 32'h0, 32'h0, c);
    rd(5'h08, 32'h0, 32'h0, v);
    check(32'(v < c), 32'h1);
    cap1 = 1'b1;
    wr(5'h10, 32'h0000_0091);
    repeat (6) @(negedge clk_sys);
    rd(5'h10, 32'h0, 32'h100, v);
    cap1 = 1'b0;
    repeat (6) @(negedge clk_sys);
    rd(5'h10, 32'h100, 32'h100, v);
    wr(5'h10, 32'h0000_0191);
    cap1 = 1'b1;
    repeat (6) @(negedge clk_sys);
    rd(5'h10, 32'h0, 32'h100, v);
    l1 = 32'($urandom_range(9, 3));
    wr(5'h04, 32'd20);
    wr(5'h14, l1);
    wr(5'h00, 32'h0000_0336);
    wr(5'h10, 32'h0000_0236);
    wr(5'h00, 32'h0000_0216);
    wr(5'h10, 32'h0000_0216);
    wr(5'h00, 32'h0000_0616);
    n = 0;
    while (pwm !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(gen0), 32'h1);
    n = 0;
    while (pwm === 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(gen1), 32'h1);
    check(32'(n), l1 + 32'd2);
    while (pwm !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check(32'(n), 32'd22);
    rd(5'h00, 32'h100, 32'h100, v);
    complete_run();
  end
endmodule
